// ===== scs_clock_select.v
// System clock source selection, internal divider and internal oscillator suspend.
// Assumes oscillator and multiplier clocks arrive as levels synchronous to clock.
`timescale 1ns/100ps
`include "scs_regs.vh"

module scs_clock_select
#(
    parameter DIV_W = 3
)
(
    // Clock and reset.
    input  wire       clock,
    input  wire       sys_rst,
    // Register port.
    input  wire [7:0] sfr_addr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_wr,
    output reg  [7:0] sfr_rdata_ff,
    // Oscillator sources.
    input  wire       int_osc_clk,
    input  wire       ext_osc_clk,
    input  wire       mult_clk,
    input  wire       xtal_settled,
    // Wake events.
    input  wire [3:0] port_match,
    input  wire       cmp0_enabled,
    input  wire       cmp0_out,
    // Clock outputs.
    output reg        system_clock_ff,
    output reg        periph_ext_clk_ff,
    output reg        suspended_ff
);

    reg [1:0]             clock_source_field_ff;
    reg [1:0]             internal_osc_enable_field_ff;
    reg [DIV_W-1:0]       internal_divider_field_ff;
    reg                   ext_osc_en_ff;
    reg                   crystal_valid_flag_ff;
    reg [1:0]             active_src_ff;
    reg [DIV_W-1:0]       active_div_ff;
    reg [`SCS_CNT_W-1:0]  div_cnt_ff;
    reg                   div_clk_ff;
    reg                   int_osc_d_ff;
    reg                   int_pass_ff;
    reg [`SCS_CNT_W-1:0]  nxt_div_cnt;
    reg                   nxt_sel_clk;
    reg [7:0]             nxt_rdata;
    wire [`SCS_CNT_W-1:0] half_period;
    wire                  int_rise;
    wire                  wake;
    wire                  osc_running;
    wire                  div_bypass;
    wire                  int_path;
    wire                  wr_clk_sel;
    wire                  wr_int_ctl;
    wire                  wr_ext_ctl;

    assign wr_clk_sel  = sfr_wr && (sfr_addr == `SCS_ADDR_CLK_SEL);
    assign wr_int_ctl  = sfr_wr && (sfr_addr == `SCS_ADDR_INT_OSC_CTL);
    assign wr_ext_ctl  = sfr_wr && (sfr_addr == `SCS_ADDR_EXT_OSC_CTL);
    assign wake        = (|port_match) || (cmp0_enabled && !cmp0_out);
    assign osc_running = (internal_osc_enable_field_ff == `SCS_OSC_EN_ON) && !suspended_ff;
    assign int_rise    = int_osc_clk && !int_osc_d_ff && osc_running;
    // Code 000 gives 64 source edges per half period, i.e. divide by 128.
    // Code 111 cannot be made by toggling, so the oscillator level passes straight through.
    assign div_bypass  = (active_div_ff == `SCS_DIV_MAX);
    assign half_period = div_bypass ? `SCS_CNT_ONE
                                    : (`SCS_CNT_ONE << (`SCS_DIV_HALF_TOP - active_div_ff));
    // The pass gate opens only while the oscillator is low, so no clipped first pulse.
    assign int_path    = div_bypass ? (int_osc_clk && int_pass_ff) : div_clk_ff;

    // Register writes and suspend control.
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clock_source_field_ff        <= `SCS_CLK_SEL_RESET;
            internal_osc_enable_field_ff <= `SCS_OSC_EN_RESET;
            internal_divider_field_ff    <= `SCS_DIV_RESET;
            ext_osc_en_ff                <= 1'b0;
            crystal_valid_flag_ff        <= 1'b0;
            suspended_ff                 <= 1'b0;
        end
        else
        begin
            if (wr_clk_sel)
            begin
                clock_source_field_ff <= sfr_wdata[`SCS_SRC_HI:`SCS_SRC_LO];
            end
            if (wr_int_ctl)
            begin
                internal_osc_enable_field_ff <= sfr_wdata[`SCS_OSC_EN_HI:`SCS_OSC_EN_LO];
                internal_divider_field_ff    <= sfr_wdata[DIV_W-1:0];
            end
            if (wr_ext_ctl)
            begin
                ext_osc_en_ff <= sfr_wdata[`SCS_EXT_EN_BIT];
            end
            crystal_valid_flag_ff <= ext_osc_en_ff && xtal_settled;
            // Wake wins over a simultaneous suspend write so no wake is lost.
            if (wake)
            begin
                suspended_ff <= 1'b0;
            end
            else if (wr_int_ctl && sfr_wdata[`SCS_SUSPEND_BIT])
            begin
                suspended_ff <= 1'b1;
            end
        end
    end

    // Internal divider: counts rising edges of the running internal oscillator.
    always @*
    begin
        nxt_div_cnt = div_cnt_ff;
        if (int_rise)
        begin
            if (div_cnt_ff >= half_period - `SCS_CNT_ONE)
            begin
                nxt_div_cnt = `SCS_CNT_ZERO;
            end
            else
            begin
                nxt_div_cnt = div_cnt_ff + `SCS_CNT_ONE;
            end
        end
    end

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_osc_d_ff  <= 1'b0;
            int_pass_ff   <= 1'b0;
            div_cnt_ff    <= `SCS_CNT_ZERO;
            div_clk_ff    <= 1'b0;
            active_div_ff <= `SCS_DIV_RESET;
        end
        else
        begin
            int_osc_d_ff <= int_osc_clk;
            int_pass_ff  <= osc_running && (int_pass_ff || !int_osc_clk);
            // A stopped oscillator restarts the divided clock from its low phase.
            if (!osc_running)
            begin
                div_cnt_ff <= `SCS_CNT_ZERO;
                div_clk_ff <= 1'b0;
            end
            else
            begin
                div_cnt_ff <= nxt_div_cnt;
                if (int_rise && (div_cnt_ff >= half_period - `SCS_CNT_ONE))
                begin
                    div_clk_ff <= !div_clk_ff;
                end
            end
            // New divide ratio only while both divided clock and oscillator are low.
            if (!div_clk_ff && (div_cnt_ff == `SCS_CNT_ZERO) && !int_osc_clk)
            begin
                active_div_ff <= internal_divider_field_ff;
            end
        end
    end

    // Source mux; a switch happens only while both the output and the currently selected clock are low.
    always @*
    begin
        case (active_src_ff)
            `SCS_SRC_INT:  nxt_sel_clk = int_path && !suspended_ff;
            `SCS_SRC_EXT:  nxt_sel_clk = ext_osc_clk;
            `SCS_SRC_MULT: nxt_sel_clk = mult_clk;
            default:       nxt_sel_clk = 1'b0;
        endcase
    end

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            active_src_ff     <= `SCS_SRC_INT;
            system_clock_ff   <= 1'b0;
            periph_ext_clk_ff <= 1'b0;
        end
        else
        begin
            if (!system_clock_ff && !nxt_sel_clk && (clock_source_field_ff != active_src_ff))
            begin
                active_src_ff <= clock_source_field_ff;
            end
            system_clock_ff   <= nxt_sel_clk;
            periph_ext_clk_ff <= ext_osc_clk && ext_osc_en_ff;
        end
    end

    // Read data.
    always @*
    begin
        case (sfr_addr)
            `SCS_ADDR_CLK_SEL:
                nxt_rdata = {6'h00, clock_source_field_ff};
            `SCS_ADDR_INT_OSC_CTL:
                nxt_rdata = {internal_osc_enable_field_ff, suspended_ff, osc_running,
                             1'b0, internal_divider_field_ff};
            `SCS_ADDR_EXT_OSC_CTL:
                nxt_rdata = {crystal_valid_flag_ff, ext_osc_en_ff, 6'h00};
            default:
                nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sfr_rdata_ff <= 8'h00;
        end
        else
        begin
            sfr_rdata_ff <= nxt_rdata;
        end
    end

endmodule

// ===== scs_regs.vh
// Register addresses, field positions and reset values of the clock select block.
// Assumes a byte-wide special function register port with a one-cycle write strobe.
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

`define SCS_ADDR_CLK_SEL      8'h8F
`define SCS_ADDR_INT_OSC_CTL  8'hA1
`define SCS_ADDR_EXT_OSC_CTL  8'hB1
`define SCS_CLK_SEL_RESET     2'h0
`define SCS_SRC_INT           2'h0
`define SCS_SRC_EXT           2'h1
`define SCS_SRC_MULT          2'h2
`define SCS_OSC_EN_RESET      2'h3
`define SCS_OSC_EN_ON         2'h3
`define SCS_OSC_EN_OFF        2'h0
`define SCS_DIV_RESET         3'h0
`define SCS_DIV_MAX           3'h7
`define SCS_DIV_HALF_TOP      3'h6
`define SCS_OSC_EN_HI         7
`define SCS_OSC_EN_LO         6
`define SCS_SRC_HI            1
`define SCS_SRC_LO            0
`define SCS_SUSPEND_BIT       5
`define SCS_RDY_BIT           4
`define SCS_XTAL_VALID_BIT    7
`define SCS_EXT_EN_BIT        6
`define SCS_CNT_W             7
`define SCS_CNT_ZERO          7'h00
`define SCS_CNT_ONE           7'h01

`endif

// ===== scs_osc_model.sv
// Oscillator levels and crystal settle flag for the clock select block.
// Changes on the falling edge of clock; all levels low in reset.
`timescale 1ns/100ps
module scs_osc_model
#(
    parameter SETTLE = 5000
)
(
    // Clock and reset.
    input  wire clock,
    input  wire sys_rst,
    // Oscillator levels.
    output reg  int_ff,
    output reg  ext_ff,
    output reg  mult_ff,
    output reg  settled_ff
);
    integer n_ff;
    always @(negedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            n_ff       <= 0;
            int_ff     <= 1'b0;
            ext_ff     <= 1'b0;
            mult_ff    <= 1'b0;
            settled_ff <= 1'b0;
        end
        else
        begin
            n_ff       <= n_ff + 1;
            int_ff     <= n_ff % 4 < 2;
            ext_ff     <= n_ff % 6 < 3;
            mult_ff    <= n_ff % 10 < 5;
            settled_ff <= n_ff >= SETTLE;
        end
    end
endmodule

// ===== scs_clock_select_chk.sv
// Assertions on the register, suspend and clock ports of the clock select block.
// Bound to scs_clock_select by the testbench; one clock domain.
`timescale 1ns/100ps
module scs_clock_select_chk
(
    // Clock, reset and register port.
    input wire       clock,
    input wire       sys_rst,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_wr,
    input wire [7:0] sfr_rdata_ff,
    // Wake events and clock outputs.
    input wire [3:0] port_match,
    input wire       cmp0_enabled,
    input wire       cmp0_out,
    input wire       system_clock_ff,
    input wire       periph_ext_clk_ff,
    input wire       suspended_ff
);
    reg  [1:0] src_ff;
    reg        ext_ff;
    wire       wake = (|port_match) | (cmp0_enabled & ~cmp0_out);
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            src_ff <= 2'h0;
            ext_ff <= 1'b0;
        end
        else
        begin
            if (sfr_wr && sfr_addr == 8'h8F) src_ff <= sfr_wdata[1:0];
            if (sfr_wr && sfr_addr == 8'hB1) ext_ff <= sfr_wdata[6];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    suspend_enter_a: assert property (sfr_wr && sfr_addr == 8'hA1 && sfr_wdata[5] && !wake
        |=> suspended_ff) else $error("suspend lost");
    wake_exit_a: assert property (suspended_ff && wake |=> !suspended_ff)
        else $error("no wake");
    suspend_hold_a: assert property (suspended_ff && !wake && !sfr_wr |=> suspended_ff)
        else $error("early wake");
    clock_stopped_a: assert property (suspended_ff && $past(suspended_ff) && src_ff == 2'h0
        |-> !system_clock_ff)
        else $error("clock runs");
    select_read_a: assert property (sfr_addr == 8'h8F && !sfr_wr |=> sfr_rdata_ff == src_ff)
        else $error("select read");
    ready_read_a: assert property (sfr_addr == 8'hA1 |=> sfr_rdata_ff[4] ==
        (sfr_rdata_ff[7:6] == 2'h3 && !sfr_rdata_ff[5])) else $error("ready flag");
    periph_gated_a: assert property (!ext_ff && !$past(ext_ff) |-> !periph_ext_clk_ff)
        else $error("periph ungated");
    no_runt_a: assert property ($rose(system_clock_ff) && !suspended_ff |=> system_clock_ff)
        else $error("runt pulse");
endmodule

// ===== scs_tb.sv
// Self-checking testbench of the clock select block with oscillator model.
// Register writes are one-cycle strobes launched at the falling edge.
`timescale 1ns/100ps
module testbench;
    reg        clock, sys_rst, sfr_wr, cmp0_enabled, cmp0_out;
    reg  [7:0] sfr_addr, sfr_wdata;
    reg  [3:0] port_match;
    wire [7:0] sfr_rdata_ff;
    wire       int_osc_clk, ext_osc_clk, mult_clk, xtal_settled;
    wire       system_clock_ff, periph_ext_clk_ff, suspended_ff;
    integer    err_total = 0, comparisons = 0, cycles = 0, k;
    scs_osc_model i_scs_osc_model (.clock(clock), .sys_rst(sys_rst), .int_ff(int_osc_clk),
        .ext_ff(ext_osc_clk), .mult_ff(mult_clk), .settled_ff(xtal_settled));
    scs_clock_select i_scs_clock_select (.clock(clock), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rdata_ff(sfr_rdata_ff), .int_osc_clk(int_osc_clk), .ext_osc_clk(ext_osc_clk),
        .mult_clk(mult_clk), .xtal_settled(xtal_settled), .port_match(port_match),
        .cmp0_enabled(cmp0_enabled), .cmp0_out(cmp0_out), .system_clock_ff(system_clock_ff),
        .periph_ext_clk_ff(periph_ext_clk_ff), .suspended_ff(suspended_ff));
    task finish_test;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task chk(input ok);
    begin
        comparisons = comparisons + 1;
        if (ok !== 1'b1)
        begin
            err_total = err_total + 1;
            $display("MISMATCH %0t compare failed", $time);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
        @(negedge clock);
    end
    endtask
    task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
        sfr_addr = a;
        @(negedge clock);
        chk((sfr_rdata_ff & m) === e);
    end
    endtask
    // Counts output edges over 240 cycles against an expected period.
    task rate(input sel, input integer per);
        integer i, n;
        reg     p, c;
    begin
        n = 0;
        p = sel ? periph_ext_clk_ff : system_clock_ff;
        for (i = 0; i < 240; i = i + 1)
        begin
            @(negedge clock);
            c = sel ? periph_ext_clk_ff : system_clock_ff;
            if (c !== p)
                n = n + 1;
            p = c;
        end
        chk(n >= 480 / per - 1 && n <= 480 / per + 1);
    end
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            err_total = err_total + 1;
            finish_test;
        end
    end
    initial
    begin
        {sys_rst, sfr_wr, cmp0_enabled, cmp0_out} = 4'h9;
        {sfr_addr, sfr_wdata, port_match} = 20'h0_0000;
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        rd(8'h8F, 8'hFF, 8'h00);
        rd(8'hA1, 8'hFF, 8'hD0);
        rd(8'h00, 8'hFF, 8'h00);
        wr(8'h8F, 8'hFF);
        rd(8'h8F, 8'hFF, 8'h03);
        wr(8'h8F, 8'h00);
        for (k = 7; k >= 4; k = k - 1)
        begin
            wr(8'hA1, 8'hC0 | k[7:0]);
            repeat (600) @(negedge clock);
            rate(1'b0, 4 << (7 - k));
        end
        wr(8'hA1, 8'hC7);
        wr(8'hB1, 8'h40);
        rd(8'hB1, 8'h80, 8'h00);
        rate(1'b1, 6);
        repeat (10000) @(negedge clock);
        rd(8'hB1, 8'hC0, 8'hC0);
        // Flash timing is outside this block and taken as set before the multiplier is picked.
        for (k = 1; k >= 0; k = k - 1)
        begin
            wr(8'h8F, 8'h02 >> k);
            repeat (100) @(negedge clock);
            rate(1'b0, 6 + 4 * (1 - k));
        end
        // Reference keepalive is outside this block and taken as set before each suspend.
        for (k = 0; k < 6; k = k + 1)
        begin
            wr(8'h8F, 8'h00);
            cmp0_enabled = (k == 4);
            cmp0_out = (k != 5);
            repeat (100) @(negedge clock);
            wr(8'hA1, 8'hE7);
            repeat (20) @(negedge clock);
            chk(suspended_ff === 1'b1 && system_clock_ff === 1'b0);
            rd(8'hA1, 8'hFF, 8'hE7);
            if (k < 4)
                port_match = 4'h1 << k;
            else
                {cmp0_enabled, cmp0_out} = 2'b10;
            repeat (2) @(negedge clock);
            chk(suspended_ff === 1'b0);
            {port_match, cmp0_enabled, cmp0_out} = 6'h01;
        end
        repeat (10) @(negedge clock);
        rate(1'b0, 4);
        finish_test;
    end
endmodule
bind scs_clock_select scs_clock_select_chk i_scs_clock_select_chk (.clock(clock),
    .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rdata_ff(sfr_rdata_ff), .port_match(port_match), .cmp0_enabled(cmp0_enabled),
    .cmp0_out(cmp0_out), .system_clock_ff(system_clock_ff),
    .periph_ext_clk_ff(periph_ext_clk_ff), .suspended_ff(suspended_ff));
